/* hdl/pmcp_protect.sv */
// Program memory, data EEPROM and configuration access protection
// Notes on behaviour
// - Lowest 512 bytes form the boot block
// - Four binary-aligned blocks; 2,3 only large
// - Each block: code, write, table-read protect
// - Code-protect bits gate only external programmer
// - Write-protected block rejects processor table writes
// - Read-protected block: outside readers get zeros
// - Protection bits clear by write; erase sets
// - EEPROM code/write protect gate external accesses
// - Processor EEPROM access allowed unless programmer requests
// - Config write protect, programmer-only writable
// - Table ops reach memory, config, device id
// - Eight ID words always readable and writable
// - Option bit dedicates select pin to programming
// - Option set as shipped; clear means HV only
// - Option changes only in high-voltage session
// - High-voltage entry always accepted
// - Debug bit zero enables debugger; pin use set by option bit only
`timescale 1ns/1ps
`default_nettype none
module pmcp_protect
  import pmcp_pkg::*;
#(
  parameter bit LARGE_MEM = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Processor table access
  input wire logic cpu_req,
  input wire logic cpu_wr,
  input wire logic [21:0] cpu_addr,
  input wire logic [21:0] cpu_pc,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  output logic cpu_ack,
  output logic cpu_err,
  // Processor data EEPROM access
  input wire logic cpu_ee_req,
  input wire logic cpu_ee_wr,
  output logic cpu_ee_grant,
  // External programmer
  input wire logic ext_req,
  input wire logic ext_wr,
  input wire logic ext_ee,
  input wire logic [21:0] ext_addr,
  input wire logic [7:0] ext_wdata,
  input wire logic ext_erase,
  output logic [7:0] ext_rdata,
  output logic ext_ack,
  output logic ext_err,
  // Programming entry pins
  input wire logic prog_select_pin,
  input wire logic reset_prog_voltage_pin,
  output logic prog_mode,
  output logic hv_session,
  output logic pin_gpio_free,
  output logic debug_enable,
  // Flash array side
  output logic fl_req,
  output logic fl_wr,
  output logic fl_ee,
  output logic [21:0] fl_addr,
  output logic [7:0] fl_wdata,
  input wire logic [7:0] fl_rdata
);

  typedef struct packed {
    logic [1:0] sel_s;
    logic [1:0] hv_s;
    logic prog;
    logic hv;
    logic [7:0] dbg_lvp;
    logic [3:0] blk_cp;
    logic boot_cp;
    logic ee_cp;
    logic [3:0] blk_wp;
    logic boot_wp;
    logic ee_wp;
    logic cfg_wp;
    logic [3:0] blk_tr;
    logic boot_tr;
    logic [7:0] cpu_rdata;
    logic cpu_ack;
    logic cpu_err;
    logic [7:0] ext_rdata;
    logic ext_ack;
    logic ext_err;
    logic fl_req;
    logic fl_wr;
    logic fl_ee;
    logic [21:0] fl_addr;
    logic [7:0] fl_wdata;
  } pmcp_st_t;

  pmcp_st_t st_q;
  pmcp_st_t st_d;

  // Block index of an address, BLK_NONE when unimplemented
  function automatic logic [2:0] pmcp_blk(input logic [21:0] a);
    logic [21:0] top;
    top = LARGE_MEM ? LARGE_TOP : SMALL_TOP;
    if (a > top) begin
      pmcp_blk = BLK_NONE;
    end else if (a <= BOOT_END) begin
      pmcp_blk = BLK_BOOT;
    end else if (a < BLK1_BASE) begin
      pmcp_blk = 3'h0;
    end else if (a < BLK2_BASE) begin
      pmcp_blk = 3'h1;
    end else if (a < BLK3_BASE) begin
      pmcp_blk = 3'h2;
    end else begin
      pmcp_blk = 3'h3;
    end
  endfunction

  // Select one of five per-block bits
  function automatic logic pmcp_bit(input logic [2:0] b, input logic [3:0] blk, input logic boot);
    if (b == BLK_BOOT) begin
      pmcp_bit = boot;
    end else if (b[2]) begin
      pmcp_bit = 1'b0;
    end else begin
      pmcp_bit = blk[b[1:0]];
    end
  endfunction

  // Config byte readback
  function automatic logic [7:0] pmcp_cfg(input pmcp_st_t s, input logic [21:0] a);
    case (a)
      DEBUG_LVP_OFS: pmcp_cfg = s.dbg_lvp;
      CP_LOW_OFS: pmcp_cfg = {4'h0, s.blk_cp};
      CP_HIGH_OFS: pmcp_cfg = {s.ee_cp, s.boot_cp, 6'h00};
      WP_LOW_OFS: pmcp_cfg = {4'h0, s.blk_wp};
      WP_HIGH_OFS: pmcp_cfg = {s.ee_wp, s.boot_wp, s.cfg_wp, 5'h00};
      TR_LOW_OFS: pmcp_cfg = {4'h0, s.blk_tr};
      TR_HIGH_OFS: pmcp_cfg = {1'b0, s.boot_tr, 6'h00};
      default: pmcp_cfg = 8'h00;
    endcase
  endfunction

  // Apply a config write: bits only go one to zero
  function automatic pmcp_st_t pmcp_cfg_wr(input pmcp_st_t s, input logic [21:0] a,
                                           input logic [7:0] d, input logic ext);
    pmcp_st_t n;
    n = s;
    case (a)
      DEBUG_LVP_OFS: begin
        n.dbg_lvp = s.dbg_lvp & d;
        if (!(ext && s.hv)) begin
          n.dbg_lvp[LVP_BIT] = s.dbg_lvp[LVP_BIT];
        end
      end
      CP_LOW_OFS: n.blk_cp = s.blk_cp & d[3:0];
      CP_HIGH_OFS: begin
        n.ee_cp = s.ee_cp & d[EE_CP_BIT];
        n.boot_cp = s.boot_cp & d[BOOT_CP_BIT];
      end
      WP_LOW_OFS: n.blk_wp = s.blk_wp & d[3:0];
      WP_HIGH_OFS: begin
        n.ee_wp = s.ee_wp & d[EE_WP_BIT];
        n.boot_wp = s.boot_wp & d[BOOT_WP_BIT];
        if (ext) begin
          n.cfg_wp = s.cfg_wp & d[CFG_WP_BIT];
        end
      end
      TR_LOW_OFS: n.blk_tr = s.blk_tr & d[3:0];
      TR_HIGH_OFS: n.boot_tr = s.boot_tr & d[BOOT_TR_BIT];
      default: n = s;
    endcase
    pmcp_cfg_wr = n;
  endfunction

  logic [2:0] cpu_blk;
  logic [2:0] pc_blk;
  logic [2:0] ext_blk;
  logic cpu_is_cfg;
  logic cpu_is_id;
  logic cpu_is_devid;
  logic ext_is_cfg;

  // Same-cycle block decode of access and fetch addresses
  always_comb begin
    cpu_blk = pmcp_blk(cpu_addr);
    pc_blk = pmcp_blk(cpu_pc);
    ext_blk = pmcp_blk(ext_addr);
    cpu_is_cfg = (cpu_addr >= CFG_BASE) && (cpu_addr <= CFG_LAST);
    cpu_is_id = (cpu_addr >= ID_BASE) && (cpu_addr <= ID_LAST);
    cpu_is_devid = (cpu_addr >= DEVID_BASE);
    ext_is_cfg = (ext_addr >= CFG_BASE) && (ext_addr <= CFG_LAST);
  end

  // Next-state logic; external port wins the flash when both ask
  always_comb begin
    st_d = st_q;
    st_d.sel_s = {st_q.sel_s[0], prog_select_pin};
    st_d.hv_s = {st_q.hv_s[0], reset_prog_voltage_pin};
    st_d.cpu_ack = 1'b0;
    st_d.cpu_err = 1'b0;
    st_d.ext_ack = 1'b0;
    st_d.ext_err = 1'b0;
    st_d.fl_req = 1'b0;
    st_d.fl_wr = 1'b0;
    st_d.fl_ee = 1'b0;
    // Entry: high voltage always, select pin only with option set
    st_d.hv = st_q.hv_s[1];
    st_d.prog = st_q.hv_s[1] || (st_q.sel_s[1] && st_q.dbg_lvp[LVP_BIT]);
    if (ext_req && st_q.prog) begin
      st_d.ext_ack = 1'b1;
      st_d.fl_addr = ext_addr;
      st_d.fl_wdata = ext_wdata;
      st_d.ext_rdata = 8'h00;
      if (ext_erase) begin
        // Erase restores every protection bit to one
        st_d.blk_cp = 4'hf;
        st_d.boot_cp = 1'b1;
        st_d.ee_cp = 1'b1;
        st_d.blk_wp = 4'hf;
        st_d.boot_wp = 1'b1;
        st_d.ee_wp = 1'b1;
        st_d.cfg_wp = 1'b1;
        st_d.blk_tr = 4'hf;
        st_d.boot_tr = 1'b1;
      end else if (ext_ee) begin
        if (!st_q.ee_cp || (ext_wr && !st_q.ee_wp)) begin
          st_d.ext_err = 1'b1;
        end else begin
          st_d.fl_req = 1'b1;
          st_d.fl_wr = ext_wr;
          st_d.fl_ee = 1'b1;
        end
      end else if (ext_is_cfg) begin
        if (ext_wr) begin
          if (!st_q.cfg_wp) begin
            st_d.ext_err = 1'b1;
          end else begin
            st_d = pmcp_cfg_wr(st_d, ext_addr, ext_wdata, 1'b1);
          end
        end else begin
          st_d.ext_rdata = pmcp_cfg(st_q, ext_addr);
        end
      end else if (ext_blk != BLK_NONE) begin
        if (!pmcp_bit(ext_blk, st_q.blk_cp, st_q.boot_cp)) begin
          st_d.ext_err = 1'b1;
        end else begin
          st_d.fl_req = 1'b1;
          st_d.fl_wr = ext_wr;
        end
      end else begin
        // ID words and unmapped space pass through to the array
        st_d.fl_req = 1'b1;
        st_d.fl_wr = ext_wr;
      end
    end else if (ext_req) begin
      st_d.ext_ack = 1'b1;
      st_d.ext_err = 1'b1;
    end else if (cpu_ee_req) begin
      st_d.fl_req = 1'b1;
      st_d.fl_wr = cpu_ee_wr;
      st_d.fl_ee = 1'b1;
      st_d.fl_addr = cpu_addr;
      st_d.fl_wdata = cpu_wdata;
    end else if (cpu_req) begin
      st_d.cpu_ack = 1'b1;
      st_d.cpu_rdata = 8'h00;
      st_d.fl_addr = cpu_addr;
      st_d.fl_wdata = cpu_wdata;
      if (cpu_is_cfg) begin
        if (cpu_wr) begin
          if (!st_q.cfg_wp) begin
            st_d.cpu_err = 1'b1;
          end else begin
            st_d = pmcp_cfg_wr(st_d, cpu_addr, cpu_wdata, 1'b0);
          end
        end else begin
          st_d.cpu_rdata = pmcp_cfg(st_q, cpu_addr);
        end
      end else if (cpu_is_devid) begin
        st_d.cpu_err = cpu_wr;
        st_d.cpu_rdata = cpu_addr[0] ? DEVID_HI_VAL : DEVID_LO_VAL;
      end else if (cpu_is_id) begin
        st_d.fl_req = 1'b1;
        st_d.fl_wr = cpu_wr;
      end else if (cpu_blk == BLK_NONE) begin
        st_d.cpu_err = cpu_wr;
      end else if (cpu_wr) begin
        if (!pmcp_bit(cpu_blk, st_q.blk_wp, st_q.boot_wp)) begin
          st_d.cpu_err = 1'b1;
        end else begin
          st_d.fl_req = 1'b1;
          st_d.fl_wr = 1'b1;
        end
      end else if (!pmcp_bit(cpu_blk, st_q.blk_tr, st_q.boot_tr) && (pc_blk != cpu_blk)) begin
        st_d.cpu_err = 1'b1;
      end else begin
        st_d.fl_req = 1'b1;
      end
    end
  end

  // State register; protection bits start erased
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= '0;
      st_q.dbg_lvp <= ERASED;
      st_q.blk_cp <= ERASED[3:0];
      st_q.boot_cp <= 1'b1;
      st_q.ee_cp <= 1'b1;
      st_q.blk_wp <= ERASED[3:0];
      st_q.boot_wp <= 1'b1;
      st_q.ee_wp <= 1'b1;
      st_q.cfg_wp <= 1'b1;
      st_q.blk_tr <= ERASED[3:0];
      st_q.boot_tr <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Read data from the array arrives one cycle after the strobe
  logic rd_cpu_q;
  logic rd_ext_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_cpu_q <= 1'b0;
      rd_ext_q <= 1'b0;
    end else begin
      rd_cpu_q <= st_q.fl_req && !st_q.fl_wr && !st_q.fl_ee && st_q.cpu_ack;
      rd_ext_q <= st_q.fl_req && !st_q.fl_wr && st_q.ext_ack;
    end
  end

  // Outputs
  assign cpu_rdata = rd_cpu_q ? fl_rdata : st_q.cpu_rdata;
  assign cpu_ack = st_q.cpu_ack;
  assign cpu_err = st_q.cpu_err;
  assign cpu_ee_grant = cpu_ee_req && !(ext_req);
  assign ext_rdata = rd_ext_q ? fl_rdata : st_q.ext_rdata;
  assign ext_ack = st_q.ext_ack;
  assign ext_err = st_q.ext_err;
  assign prog_mode = st_q.prog;
  assign hv_session = st_q.hv;
  assign pin_gpio_free = !st_q.dbg_lvp[LVP_BIT];
  assign debug_enable = !st_q.dbg_lvp[DEBUG_BIT];
  assign fl_req = st_q.fl_req;
  assign fl_wr = st_q.fl_wr;
  assign fl_ee = st_q.fl_ee;
  assign fl_addr = st_q.fl_addr;
  assign fl_wdata = st_q.fl_wdata;

endmodule
`default_nettype wire

/* hdl/pmcp_pkg.sv */
// Package: address map, protection config offsets, field positions and reset values
package pmcp_pkg;
  // Program memory block boundaries
  localparam logic [21:0] BOOT_END = 22'h0001ff;
  localparam logic [21:0] BLK1_BASE = 22'h002000;
  localparam logic [21:0] BLK2_BASE = 22'h004000;
  localparam logic [21:0] BLK3_BASE = 22'h006000;
  localparam logic [21:0] SMALL_TOP = 22'h003fff;
  localparam logic [21:0] LARGE_TOP = 22'h007fff;
  // User ID window
  localparam logic [21:0] ID_BASE = 22'h200000;
  localparam logic [21:0] ID_LAST = 22'h200007;
  // Configuration space
  localparam logic [21:0] CFG_BASE = 22'h300000;
  localparam logic [21:0] CFG_LAST = 22'h30000d;
  localparam logic [21:0] DEVID_BASE = 22'h3ffffe;
  localparam logic [21:0] DEBUG_LVP_OFS = 22'h300006;
  localparam logic [21:0] CP_LOW_OFS = 22'h300008;
  localparam logic [21:0] CP_HIGH_OFS = 22'h300009;
  localparam logic [21:0] WP_LOW_OFS = 22'h30000a;
  localparam logic [21:0] WP_HIGH_OFS = 22'h30000b;
  localparam logic [21:0] TR_LOW_OFS = 22'h30000c;
  localparam logic [21:0] TR_HIGH_OFS = 22'h30000d;
  // Field positions
  localparam int EE_CP_BIT = 7;
  localparam int BOOT_CP_BIT = 6;
  localparam int EE_WP_BIT = 7;
  localparam int BOOT_WP_BIT = 6;
  localparam int CFG_WP_BIT = 5;
  localparam int BOOT_TR_BIT = 6;
  localparam int LVP_BIT = 2;
  localparam int DEBUG_BIT = 7;
  // Erased (unprogrammed) value of every protection byte
  localparam logic [7:0] ERASED = 8'hff;
  // Device id words, value arbitrary
  localparam logic [7:0] DEVID_LO_VAL = 8'h5a;
  localparam logic [7:0] DEVID_HI_VAL = 8'ha5;
  // Block index codes
  localparam logic [2:0] BLK_BOOT = 3'h4;
  localparam logic [2:0] BLK_NONE = 3'h7;
endpackage

/* verification/pmcp_flash_model.sv */
// Behavioural flash array answering the protection block's strobes
`timescale 1ns/1ps
`default_nettype none
module pmcp_flash_model (
  // Clock
  input wire logic mclk,
  // Strobe from the protection block
  input wire logic fl_req,
  input wire logic fl_wr,
  input wire logic fl_ee,
  input wire logic [21:0] fl_addr,
  input wire logic [7:0] fl_wdata,
  // Read data, valid the cycle after a read strobe
  output logic [7:0] fl_rdata
);
  logic [7:0] mem [logic [22:0]];
  initial fl_rdata = 8'h00;
  // Idle cycles invert the bus so stale data never looks valid
  always @(posedge mclk) begin
    if (fl_req && fl_wr) begin
      mem[{fl_ee, fl_addr}] = fl_wdata;
    end else if (fl_req) begin
      fl_rdata <= mem.exists({fl_ee, fl_addr}) ? mem[{fl_ee, fl_addr}] : 8'hff;
    end else begin
      fl_rdata <= ~fl_rdata;
    end
  end
endmodule
`default_nettype wire

/* verification/pmcp_checker.sv */
// Concurrent checks on the protection block's ports
`timescale 1ns/1ps
`default_nettype none
module pmcp_checker
  import pmcp_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Processor side
  input wire logic cpu_req,
  input wire logic cpu_wr,
  input wire logic [21:0] cpu_addr,
  input wire logic cpu_ack,
  input wire logic cpu_err,
  input wire logic cpu_ee_req,
  input wire logic cpu_ee_grant,
  // Programmer and pins
  input wire logic ext_req,
  input wire logic ext_ack,
  input wire logic ext_err,
  input wire logic prog_mode,
  input wire logic pin_gpio_free,
  input wire logic debug_enable,
  // Flash side
  input wire logic fl_req,
  input wire logic fl_wr,
  input wire logic fl_ee
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic take;
  // Processor request that wins arbitration
  assign take = cpu_req && !ext_req && !cpu_ee_req;
  AST_CPU_ACK: assert property (take |=> cpu_ack) else $error("cpu ack missing");
  AST_DEVID_WR: assert property (take && cpu_wr && cpu_addr == DEVID_BASE |=> cpu_err) else $error("id write ok");
  AST_UNIMPL: assert property (take && !cpu_wr && cpu_addr > LARGE_TOP && cpu_addr < ID_BASE
    |=> cpu_ack && !cpu_err) else $error("unimplemented read refused");
  AST_ERR_NOWR: assert property (cpu_err |-> cpu_ack && !(fl_req && fl_wr)) else $error("refused write hit array");
  AST_EE_GRANT: assert property (cpu_ee_req && !ext_req |-> cpu_ee_grant ##1 (fl_req && fl_ee))
    else $error("eeprom access not granted");
  AST_EXT_ACK: assert property (ext_req |=> ext_ack) else $error("ext ack missing");
  AST_EXT_NOPROG: assert property (ext_req && !prog_mode |=> ext_err) else $error("ext outside session");
  AST_EXT_ERR: assert property (ext_err |-> ext_ack) else $error("ext err without ack");
  AST_PINS_RST: assert property (disable iff (1'b0) rst |=> !prog_mode && !pin_gpio_free && !debug_enable)
    else $error("reset pin state");
  // Main scenarios
  C_CPU_ERR: cover property (cpu_err);
  C_EXT_ERR: cover property (ext_err);
  C_FL_WR: cover property (fl_req && fl_wr);
endmodule
`default_nettype wire
bind pmcp_protect pmcp_checker u_chk (.mclk, .rst, .cpu_req, .cpu_wr, .cpu_addr, .cpu_ack, .cpu_err,
  .cpu_ee_req, .cpu_ee_grant, .ext_req, .ext_ack, .ext_err, .prog_mode, .pin_gpio_free, .debug_enable,
  .fl_req, .fl_wr, .fl_ee);

/* verification/tb_program_memory_code_protection.sv */
// Self-checking bench for the memory protection block
`timescale 1ns/1ps
`default_nettype none
module tb_program_memory_code_protection;
  import pmcp_pkg::*;
  logic mclk, rst, cpu_req, cpu_wr, cpu_ack, cpu_err, cpu_ee_req, cpu_ee_wr, cpu_ee_grant;
  logic ext_req, ext_wr, ext_ee, ext_erase, ext_ack, ext_err, prog_select_pin, reset_prog_voltage_pin;
  logic prog_mode, hv_session, pin_gpio_free, debug_enable, fl_req, fl_wr, fl_ee, er;
  logic [21:0] cpu_addr, cpu_pc, ext_addr, fl_addr;
  logic [7:0] cpu_wdata, cpu_rdata, ext_wdata, ext_rdata, fl_wdata, fl_rdata, rd;
  logic [7:0] ids [8];
  int mismatches = 0;
  int compares = 0;
  pmcp_protect uut (.mclk(mclk), .rst(rst), .cpu_req(cpu_req), .cpu_wr(cpu_wr), .cpu_addr(cpu_addr),
    .cpu_pc(cpu_pc), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack), .cpu_err(cpu_err),
    .cpu_ee_req(cpu_ee_req), .cpu_ee_wr(cpu_ee_wr), .cpu_ee_grant(cpu_ee_grant), .ext_req(ext_req),
    .ext_wr(ext_wr), .ext_ee(ext_ee), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_erase(ext_erase),
    .ext_rdata(ext_rdata), .ext_ack(ext_ack), .ext_err(ext_err), .prog_select_pin(prog_select_pin),
    .reset_prog_voltage_pin(reset_prog_voltage_pin), .prog_mode(prog_mode), .hv_session(hv_session),
    .pin_gpio_free(pin_gpio_free), .debug_enable(debug_enable), .fl_req(fl_req), .fl_wr(fl_wr),
    .fl_ee(fl_ee), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_rdata(fl_rdata));
  pmcp_flash_model u_fl (.mclk(mclk), .fl_req(fl_req), .fl_wr(fl_wr), .fl_ee(fl_ee), .fl_addr(fl_addr),
    .fl_wdata(fl_wdata), .fl_rdata(fl_rdata));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic s);
    chk8(n, {7'h00, e}, {7'h00, s});
  endtask
  // One byte transfer; x picks the programmer instead of the processor
  task automatic acc(input bit x, input logic w, input logic ee, input logic [21:0] a, input logic [21:0] p,
    input logic [7:0] d);
    @(posedge mclk); #1;
    if (x) begin
      ext_req = 1'b1; ext_wr = w; ext_ee = ee; ext_addr = a; ext_wdata = d;
    end else begin
      cpu_req = 1'b1; cpu_wr = w; cpu_addr = a; cpu_pc = p; cpu_wdata = d;
    end
    @(posedge mclk); #1;
    cpu_req = 1'b0;
    ext_req = 1'b0;
    chk1("ack", 1'b1, x ? ext_ack : cpu_ack);
    er = x ? ext_err : cpu_err;
    @(posedge mclk); #1;
    rd = x ? ext_rdata : cpu_rdata;
  endtask
  // Synchroniser needs a few cycles before the session state moves
  task automatic pins(input logic hv, input logic sel);
    reset_prog_voltage_pin = hv;
    prog_select_pin = sel;
    repeat (6) @(posedge mclk);
    // Sample settled outputs, not in the launching time step
    #1;
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    complete_run;
  end
  initial begin
    {cpu_req, cpu_wr, cpu_ee_req, cpu_ee_wr, ext_req, ext_wr, ext_ee, ext_erase} = 8'h00;
    {prog_select_pin, reset_prog_voltage_pin} = 2'h0;
    {cpu_addr, cpu_pc, ext_addr} = '0;
    {cpu_wdata, ext_wdata} = 16'h0000;
    rst = 1'b1;
    void'($urandom(32'h52ab));
    repeat (4) @(posedge mclk);
    #1 rst = 1'b0;
    chk1("gpio", 1'b0, pin_gpio_free);
    acc(0, 1, 0, 22'h000200, 22'h000300, 8'h3c);
    acc(0, 0, 0, 22'h000200, 22'h000300, 8'h00);
    chk8("blk0", 8'h3c, rd);
    acc(0, 1, 0, WP_LOW_OFS, 22'h000300, 8'hfe);
    acc(0, 1, 0, 22'h000200, 22'h000300, 8'hc3);
    chk1("wp err", 1'b1, er);
    acc(0, 0, 0, 22'h000200, 22'h000300, 8'h00);
    chk8("blk0 kept", 8'h3c, rd);
    acc(0, 1, 0, WP_LOW_OFS, 22'h000300, 8'hff);
    acc(0, 0, 0, WP_LOW_OFS, 22'h000300, 8'h00);
    chk1("wp stays", 1'b0, rd[0]);
    acc(0, 1, 0, 22'h002000, 22'h000300, 8'h77);
    acc(0, 1, 0, TR_LOW_OFS, 22'h000300, 8'hfd);
    acc(0, 0, 0, 22'h002000, 22'h000300, 8'h00);
    chk8("outside read", 8'h00, rd);
    acc(0, 0, 0, 22'h002000, 22'h002100, 8'h00);
    chk8("inside read", 8'h77, rd);
    acc(0, 0, 0, 22'h008000, 22'h000300, 8'h00);
    chk8("unimpl", 8'h00, rd);
    acc(0, 0, 0, DEVID_BASE, 22'h000300, 8'h00);
    chk8("devid", DEVID_LO_VAL, rd);
    acc(0, 1, 0, DEVID_BASE, 22'h000300, 8'h00);
    chk1("devid wr", 1'b1, er);
    // Random user id contents
    for (int i = 0; i < 8; i++) begin
      ids[i] = 8'($urandom);
      acc(0, 1, 0, ID_BASE + 22'(i), 22'h000300, ids[i]);
    end
    for (int i = 0; i < 8; i++) begin
      acc(0, 0, 0, ID_BASE + 22'(i), 22'h002100, 8'h00);
      chk8("id", ids[i], rd);
    end
    acc(0, 1, 0, WP_HIGH_OFS, 22'h000300, 8'hdf);
    acc(0, 0, 0, WP_HIGH_OFS, 22'h000300, 8'h00);
    chk1("cfg wp", 1'b1, rd[CFG_WP_BIT]);
    @(posedge mclk); #1 cpu_ee_req = 1'b1;
    #1 chk1("ee grant", 1'b1, cpu_ee_grant);
    @(posedge mclk); #1 cpu_ee_req = 1'b0;
    acc(1, 0, 0, 22'h000200, 22'h0, 8'h00);
    chk1("no session", 1'b1, er);
    pins(0, 1);
    chk1("lv mode", 1'b1, prog_mode);
    chk1("lv hv", 1'b0, hv_session);
    acc(1, 1, 0, DEBUG_LVP_OFS, 22'h0, 8'hfb);
    chk1("lv keeps", 1'b0, pin_gpio_free);
    pins(1, 0);
    chk1("hv mode", 1'b1, hv_session);
    acc(1, 0, 0, 22'h000200, 22'h0, 8'h00);
    chk8("ext blk0", 8'h3c, rd);
    acc(1, 1, 0, CP_LOW_OFS, 22'h0, 8'hfe);
    acc(1, 0, 0, 22'h000200, 22'h0, 8'h00);
    chk1("cp err", 1'b1, er);
    acc(0, 0, 0, 22'h000200, 22'h000300, 8'h00);
    chk8("cpu ignores cp", 8'h3c, rd);
    acc(1, 1, 1, 22'h000010, 22'h0, 8'h99);
    acc(1, 1, 0, WP_HIGH_OFS, 22'h0, 8'h7f);
    acc(1, 1, 1, 22'h000010, 22'h0, 8'h11);
    chk1("ee wp", 1'b1, er);
    acc(1, 0, 1, 22'h000010, 22'h0, 8'h00);
    chk8("ee read", 8'h99, rd);
    acc(1, 1, 0, CP_HIGH_OFS, 22'h0, 8'h7f);
    acc(1, 0, 1, 22'h000010, 22'h0, 8'h00);
    chk1("ee cp", 1'b1, er);
    acc(1, 1, 0, DEBUG_LVP_OFS, 22'h0, 8'h7b);
    chk1("gpio free", 1'b1, pin_gpio_free);
    chk1("debug", 1'b1, debug_enable);
    // Programmer locks the config space; processor config write refused
    acc(1, 1, 0, WP_HIGH_OFS, 22'h0, 8'hdf);
    acc(0, 1, 0, CP_LOW_OFS, 22'h000300, 8'h00);
    chk1("cfg locked", 1'b1, er);
    // Erase travels with a programmer request
    ext_erase = 1'b1;
    acc(1, 0, 0, 22'h000200, 22'h0, 8'h00);
    ext_erase = 1'b0;
    chk1("erase ok", 1'b0, er);
    acc(1, 0, 0, 22'h000200, 22'h0, 8'h00);
    chk1("erased", 1'b0, er);
    pins(0, 1);
    chk1("hv only", 1'b0, prog_mode);
    complete_run;
  end
endmodule
`default_nettype wire
